// ==== logic/rdr_pkg.sv ====
`default_nettype none
package rdr_pkg;
  // ****************************************
  // Register layout
  // ****************************************
  localparam int REF_LEN = 16;
  localparam int CFG_LEN = 8;
  localparam int A_LEN = 24;
  localparam int SHIFT_LEN = 24;
  localparam int DIV_BITS = 13;
  localparam int OSC_LSB = 13;
  localparam int OSC_MSB = 15;
  localparam int POL_BIT = 7;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] OSC_RST = 3'h4;
  localparam logic [12:0] DIV_RST = 13'h0001;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [23:0] A_RST = 24'h00_0000;
  // ****************************************
  // Reference output modes
  // ****************************************
  localparam logic [2:0] OSC_LOW = 3'h0;
  localparam logic [2:0] OSC_PASS = 3'h1;
  localparam logic [2:0] OSC_DIV2 = 3'h2;
  localparam logic [2:0] OSC_DIV4 = 3'h3;
  localparam logic [2:0] OSC_DIV8 = 3'h4;
  localparam logic [2:0] OSC_DIV16 = 3'h5;

  typedef struct packed {
    logic clk;
    logic data;
    logic loadStrobe;
  } rdr_serial_s;

  typedef enum logic [3:0] {
    DET_IDLE = 4'b0001,
    DET_UP = 4'b0010,
    DET_DN = 4'b0100,
    DET_BOTH = 4'b1000
  } rdr_det_e;
endpackage
`default_nettype wire

// ==== logic/rdr_ref_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - The top three register bits select the reference output oscillator or divider mode.
// - The low thirteen register bits are the divide value of the reference counter.
// - After reset the reference output is the reference input divided by eight.
// - A 16-bit load applies the three mode bits at once and puts the divide bits only in the first buffer.
// - A 16-bit load or a bare enable pulse leaves the configuration and A registers unchanged; an A load changes A.
// - An enable pulse with no clock activity copies the first buffer to the second, keeping the first.
// - The counter ends its present count with the old ratio before using the new one.
// - Completing an A register load also copies the first buffer into the second.
// - The detector output sources or sinks when out of lock and floats once locked.
// - Comparison edges arriving in phase turn on source and sink together briefly.
module rdr_ref_divider #(
  parameter int DIV_WIDTH = 13
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire rdr_pkg::rdr_serial_s serialIn,
  input wire logic refInput,
  input wire logic vcoCompareFreq,
  output logic refOutput,
  output logic refCompareFreq,
  output logic chargePumpOutO,
  output logic chargePumpOutOe,
  output logic cpSourceOn,
  output logic cpSinkOn,
  output logic [2:0] refOscCtrlBits,
  output logic [DIV_WIDTH-1:0] refDivideBits,
  output logic [7:0] cfgBits,
  output logic [23:0] aBits
);
  if (DIV_WIDTH != rdr_pkg::DIV_BITS) begin : gChk
    $error("DIV_WIDTH must equal 13");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Every pin is asynchronous to sys_clk: two stages before any use
  logic [4:0] syncA_reg;
  logic [4:0] syncB_reg;
  logic [4:0] syncD_reg;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      syncA_reg <= 5'h1C;
      syncB_reg <= 5'h1C;
      syncD_reg <= 5'h1C;
    end
    else
    begin
      syncA_reg <= {serialIn.loadStrobe, serialIn.data, serialIn.clk, refInput, vcoCompareFreq};
      syncB_reg <= syncA_reg;
      syncD_reg <= syncB_reg;
    end
  end
  logic strobeS, dataS, sclkS, refS, vcoS;
  assign {strobeS, dataS, sclkS, refS, vcoS} = syncB_reg;
  logic sclkRise, strobeRise, refEdge, vcoEdge;
  assign sclkRise = sclkS && !syncD_reg[2];
  assign strobeRise = strobeS && !syncD_reg[4];
  assign refEdge = refS && !syncD_reg[1];
  assign vcoEdge = vcoS && !syncD_reg[0];

  // ****************************************
  // Serial port and registers
  // ****************************************
  logic [23:0] shift_reg, shift_next;
  logic [4:0] bitCnt_reg, bitCnt_next;
  logic [2:0] osc_reg, osc_next;
  logic [12:0] buf1_reg, buf1_next, buf2_reg, buf2_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [23:0] a_reg, a_next;
  logic shiftEv, rLoad, aLoad, cLoad, xferLoad;
  assign shiftEv = sclkRise && !strobeS;
  assign rLoad = strobeRise && bitCnt_reg == 5'(rdr_pkg::REF_LEN);
  assign aLoad = strobeRise && bitCnt_reg == 5'(rdr_pkg::A_LEN);
  assign cLoad = strobeRise && bitCnt_reg == 5'(rdr_pkg::CFG_LEN);
  // Relies on the host holding the clock low through the pulse
  assign xferLoad = strobeRise && bitCnt_reg == 5'h00;

  always_comb
  begin
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    osc_next = osc_reg;
    buf1_next = buf1_reg;
    buf2_next = buf2_reg;
    cfg_next = cfg_reg;
    a_next = a_reg;
    if (shiftEv)
    begin
      shift_next = {shift_reg[22:0], dataS};
      if (bitCnt_reg != rdr_pkg::CNT_MAX)
        bitCnt_next = bitCnt_reg + 5'h01;
    end
    if (strobeRise)
      bitCnt_next = 5'h00;
    if (rLoad)
    begin
      osc_next = shift_reg[rdr_pkg::OSC_MSB:rdr_pkg::OSC_LSB];
      buf1_next = shift_reg[rdr_pkg::DIV_BITS-1:0];
    end
    if (xferLoad || aLoad)
      buf2_next = buf1_reg;
    if (aLoad)
      a_next = shift_reg;
    if (cLoad)
      cfg_next = shift_reg[7:0];
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      shift_reg <= 24'h00_0000;
      bitCnt_reg <= 5'h00;
      osc_reg <= rdr_pkg::OSC_RST;
      buf1_reg <= rdr_pkg::DIV_RST;
      buf2_reg <= rdr_pkg::DIV_RST;
      cfg_reg <= rdr_pkg::CFG_RST;
      a_reg <= rdr_pkg::A_RST;
    end
    else
    begin
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      osc_reg <= osc_next;
      buf1_reg <= buf1_next;
      buf2_reg <= buf2_next;
      cfg_reg <= cfg_next;
      a_reg <= a_next;
    end
  end

  // ****************************************
  // Reference counter and output divider
  // ****************************************
  // The ratio is sampled only at reload, so a new ratio waits for the count end
  logic [12:0] cnt_reg, cnt_next;
  logic [3:0] oDiv_reg, oDiv_next;
  logic refCmp_reg, refCmp_next, ref_output_reg, ref_output_next;
  always_comb
  begin
    cnt_next = cnt_reg;
    refCmp_next = 1'b0;
    oDiv_next = oDiv_reg;
    if (refEdge)
    begin
      oDiv_next = oDiv_reg + 4'h1;
      if (cnt_reg <= 13'h0001)
      begin
        cnt_next = buf2_reg;
        refCmp_next = 1'b1;
      end
      else
        cnt_next = cnt_reg - 13'h0001;
    end
    case (osc_reg)
      rdr_pkg::OSC_LOW: ref_output_next = 1'b0;
      rdr_pkg::OSC_DIV2: ref_output_next = oDiv_reg[0];
      rdr_pkg::OSC_DIV4: ref_output_next = oDiv_reg[1];
      rdr_pkg::OSC_DIV8: ref_output_next = oDiv_reg[2];
      rdr_pkg::OSC_DIV16: ref_output_next = oDiv_reg[3];
      default: ref_output_next = refS;
    endcase
  end
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_reg <= rdr_pkg::DIV_RST;
      oDiv_reg <= 4'h0;
      refCmp_reg <= 1'b0;
      ref_output_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      oDiv_reg <= oDiv_next;
      refCmp_reg <= refCmp_next;
      ref_output_reg <= ref_output_next;
    end
  end

  // ****************************************
  // Phase/frequency detector
  // ****************************************
  // Detector compares the divided reference pulse with the synced VCO edge
  rdr_pkg::rdr_det_e det_reg, det_next;
  always_comb
  begin
    det_next = det_reg;
    case (det_reg)
      rdr_pkg::DET_IDLE:
        if (refCmp_reg && vcoEdge)
          det_next = rdr_pkg::DET_BOTH;
        else if (refCmp_reg)
          det_next = rdr_pkg::DET_UP;
        else if (vcoEdge)
          det_next = rdr_pkg::DET_DN;
      rdr_pkg::DET_UP:
        if (vcoEdge)
          det_next = rdr_pkg::DET_BOTH;
      rdr_pkg::DET_DN:
        if (refCmp_reg)
          det_next = rdr_pkg::DET_BOTH;
      rdr_pkg::DET_BOTH: det_next = rdr_pkg::DET_IDLE;
      default: det_next = rdr_pkg::DET_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      det_reg <= rdr_pkg::DET_IDLE;
    else
      det_reg <= det_next;
  end
  logic upOn, dnOn, detector_polarity;
  assign detector_polarity = cfg_reg[rdr_pkg::POL_BIT];
  assign upOn = det_reg == rdr_pkg::DET_UP || det_reg == rdr_pkg::DET_BOTH;
  assign dnOn = det_reg == rdr_pkg::DET_DN || det_reg == rdr_pkg::DET_BOTH;
  // Polarity bit swaps source and sink roles
  assign cpSourceOn = detector_polarity ? dnOn : upOn;
  assign cpSinkOn = detector_polarity ? upOn : dnOn;
  assign chargePumpOutOe = cpSourceOn ^ cpSinkOn;
  assign chargePumpOutO = cpSourceOn;

  assign refOutput = ref_output_reg;
  assign refCompareFreq = refCmp_reg;
  assign refOscCtrlBits = osc_reg;
  assign refDivideBits = buf2_reg;
  assign cfgBits = cfg_reg;
  assign aBits = a_reg;

  // ****************************************
  // Assertions
  // ****************************************
  AST_RST_DIV8: assert property (@(posedge sys_clk) $fell(reset) |-> osc_reg == 3'h4) else $error("Reset mode not div8");
  AST_RLOAD: assert property (@(posedge sys_clk) disable iff (reset)
    rLoad |=> osc_reg == $past(shift_reg[15:13]) && buf1_reg == $past(shift_reg[12:0])
      && buf2_reg == $past(buf2_reg)) else $error("R load wrong");
  AST_KEEP_CA: assert property (@(posedge sys_clk) disable iff (reset)
    (rLoad || xferLoad) |=> cfg_reg == $past(cfg_reg) && a_reg == $past(a_reg)) else $error("C or A changed");
  AST_XFER: assert property (@(posedge sys_clk) disable iff (reset)
    xferLoad |=> buf2_reg == $past(buf1_reg) && buf1_reg == $past(buf1_reg)) else $error("Transfer wrong");
  AST_COUNT: assert property (@(posedge sys_clk) disable iff (reset)
    refEdge && cnt_reg > 13'h0001 |=> cnt_reg == $past(cnt_reg) - 13'h0001) else $error("Count skipped");
  AST_RELOAD: assert property (@(posedge sys_clk) disable iff (reset)
    refEdge && cnt_reg <= 13'h0001 |=> cnt_reg == $past(buf2_reg) && refCompareFreq) else $error("Reload wrong");
  AST_ALOAD: assert property (@(posedge sys_clk) disable iff (reset)
    aLoad |=> buf2_reg == $past(buf1_reg)) else $error("A load no transfer");
  AST_LOCK_HIZ: assert property (@(posedge sys_clk) disable iff (reset)
    det_reg == rdr_pkg::DET_IDLE |-> !chargePumpOutOe && !cpSourceOn && !cpSinkOn) else $error("Drive while locked");
  AST_INPHASE: assert property (@(posedge sys_clk) disable iff (reset)
    det_reg == rdr_pkg::DET_IDLE && refCmp_reg && vcoEdge |=> cpSourceOn && cpSinkOn ##1 !cpSourceOn && !cpSinkOn)
    else $error("Both-on wrong");
  AST_SHIFT: assert property (@(posedge sys_clk) disable iff (reset)
    shiftEv && !strobeRise && bitCnt_reg < 5'h1F |=> bitCnt_reg == $past(bitCnt_reg) + 5'h01) else $error("Bit count");
  AST_DIV8_OUT: assert property (@(posedge sys_clk) disable iff (reset)
    osc_reg == 3'h4 && $stable(osc_reg) |=> refOutput == $past(oDiv_reg[2])) else $error("Ref output mode");
  COV_RLOAD: cover property (@(posedge sys_clk) disable iff (reset) rLoad);
  COV_ALOAD: cover property (@(posedge sys_clk) disable iff (reset) aLoad);
  COV_XFER: cover property (@(posedge sys_clk) disable iff (reset) xferLoad ##[1:50] refCompareFreq);
  COV_BOTH: cover property (@(posedge sys_clk) disable iff (reset) det_reg == rdr_pkg::DET_BOTH);
endmodule // rdr_ref_divider
`default_nettype wire

// ==== dv/rdr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rdr_host_model (
  input wire logic sys_clk,
  output var rdr_pkg::rdr_serial_s serialOut
);
  // ****************************************
  // Serial host
  // ****************************************
  initial serialOut = '{clk: 1'b0, data: 1'b0, loadStrobe: 1'b1};
  // Three cycles per level, above the two the pin synchronizer needs
  task automatic pins(input logic c, input logic d, input logic s);
    @(posedge sys_clk);
    #1;
    serialOut = '{clk: c, data: d, loadStrobe: s};
    repeat (2) @(posedge sys_clk);
  endtask
  // A count of zero gives a bare strobe pulse with the clock low
  task automatic sendBits(input logic [23:0] value, input int count);
    pins(1'b0, ~value[0], 1'b0);
    for (int i = count - 1; i >= 0; i--)
    begin
      pins(1'b0, value[i], 1'b0);
      pins(1'b1, value[i], 1'b0);
    end
    pins(1'b0, ~value[0], 1'b0);
    pins(1'b0, value[0], 1'b1);
    repeat (3) @(posedge sys_clk);
  endtask
endmodule // rdr_host_model
`default_nettype wire

// ==== dv/rdr_ref_divider_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module rdr_ref_divider_test;
  // ****************************************
  // Clock, reset and pins
  // ****************************************
  logic sysClk = 1'b0;
  logic reset = 1'b1;
  logic refInput = 1'b0;
  logic vcoCompareFreq = 1'b0;
  rdr_pkg::rdr_serial_s serialIn;
  logic refOutput, refCompareFreq, chargePumpOutO, chargePumpOutOe, cpSourceOn, cpSinkOn;
  logic [2:0] refOscCtrlBits;
  logic [12:0] refDivideBits;
  logic [12:0] divSeen = 13'h0000;
  logic [7:0] cfgBits;
  logic [23:0] aBits;
  int failures = 0;
  int nChecks = 0;
  int cyc = 0;
  int lastPulse = 0;
  int gap = 0;
  int oldGap = 0;
  logic armed = 1'b0;
  always #50 sysClk = ~sysClk;
  // Reference input period is six system cycles
  always
  begin
    repeat (3) @(posedge sysClk);
    #1;
    refInput = ~refInput;
  end
  // Pulse spacing, and the spacing of the first pulse after a ratio change
  // Sampled on the falling edge, where registered outputs are settled
  always @(negedge sysClk)
  begin
    cyc++;
    if (refDivideBits !== divSeen)
    begin
      divSeen = refDivideBits;
      armed = 1'b1;
    end
    if (refCompareFreq === 1'b1)
    begin
      gap = cyc - lastPulse;
      lastPulse = cyc;
      if (armed)
        oldGap = gap;
      armed = 1'b0;
    end
  end
  rdr_host_model u_rdr_host_model (.sys_clk(sysClk), .serialOut(serialIn));
  rdr_ref_divider u_rdr_ref_divider (.sys_clk(sysClk), .reset(reset), .serialIn(serialIn),
    .refInput(refInput), .vcoCompareFreq(vcoCompareFreq), .refOutput(refOutput),
    .refCompareFreq(refCompareFreq), .chargePumpOutO(chargePumpOutO), .chargePumpOutOe(chargePumpOutOe),
    .cpSourceOn(cpSourceOn), .cpSinkOn(cpSinkOn), .refOscCtrlBits(refOscCtrlBits),
    .refDivideBits(refDivideBits), .cfgBits(cfgBits), .aBits(aBits));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    nChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (failures == 0 && nChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic waitPulse;
    int n;
    n = 0;
    do
    begin
      @(posedge sysClk);
      #1;
      n++;
    end
    while (refCompareFreq !== 1'b1 && n < 100);
    check(refCompareFreq, 1'b1, "compare pulse");
    @(posedge sysClk);
    #1;
  endtask
  // Cycles between two rising edges of the reference output
  task automatic refOutPeriod(output int p);
    int n;
    n = 0;
    p = 0;
    while (refOutput !== 1'b0 && n < 500)
    begin
      @(posedge sysClk);
      #1;
      n++;
    end
    while (refOutput !== 1'b1 && n < 500)
    begin
      @(posedge sysClk);
      #1;
      n++;
    end
    while (refOutput === 1'b1 && n < 500)
    begin
      @(posedge sysClk);
      #1;
      n++;
      p++;
    end
    while (refOutput !== 1'b1 && n < 500)
    begin
      @(posedge sysClk);
      #1;
      n++;
      p++;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testReset;
    int p;
    check(refOscCtrlBits, rdr_pkg::OSC_DIV8, "mode after reset");
    check({cfgBits, aBits}, 32'h0000_0000, "cfg and A after reset");
    refOutPeriod(p);
    check(p, 48, "ref output divided by eight");
  endtask
  task automatic testRegLoad;
    u_rdr_host_model.sendBits(24'h00_A005, 16);
    check(refOscCtrlBits, 3'h5, "mode applied at once");
    check(refDivideBits, 13'h0001, "ratio held in first buffer");
    check({cfgBits, aBits}, 32'h0000_0000, "cfg and A kept");
    u_rdr_host_model.sendBits(24'h00_0000, 0);
    check(refDivideBits, 13'h0005, "transfer pulse");
    u_rdr_host_model.sendBits(24'h00_0000, 0);
    check(refDivideBits, 13'h0005, "first buffer kept");
    check({cfgBits, aBits, refOscCtrlBits}, 35'h0_0000_0005, "others kept");
    waitPulse();
    waitPulse();
    check(gap, 30, "divide by five");
  endtask
  task automatic testDetector;
    int n;
    waitPulse();
    @(posedge sysClk);
    #1;
    check({chargePumpOutOe, chargePumpOutO, cpSourceOn, cpSinkOn}, 4'b1110, "source out of lock");
    vcoCompareFreq = 1'b1;
    n = 0;
    while (!(cpSourceOn === 1'b1 && cpSinkOn === 1'b1) && n < 8)
    begin
      @(posedge sysClk);
      #1;
      n++;
    end
    check({cpSourceOn, cpSinkOn}, 2'b11, "both on at edge");
    @(posedge sysClk);
    #1;
    check({chargePumpOutOe, cpSourceOn, cpSinkOn}, 3'b000, "released after edge");
    vcoCompareFreq = 1'b0;
    // Next compare pulse is 30 cycles after the last; time the VCO edge onto it
    repeat (22) @(posedge sysClk);
    #1;
    vcoCompareFreq = 1'b1;
    repeat (3) @(posedge sysClk);
    #1;
    check({chargePumpOutOe, cpSourceOn, cpSinkOn}, 3'b011, "both on in phase");
    @(posedge sysClk);
    #1;
    check({chargePumpOutOe, cpSourceOn, cpSinkOn}, 3'b000, "released in phase");
    vcoCompareFreq = 1'b0;
  endtask
  task automatic testALoad;
    int p;
    u_rdr_host_model.sendBits(24'h00_4003, 16);
    check(refDivideBits, 13'h0005, "ratio not yet moved");
    u_rdr_host_model.sendBits(24'h12_3456, 24);
    check(aBits, 24'h12_3456, "A register");
    check(refDivideBits, 13'h0003, "A load moves ratio");
    waitPulse();
    waitPulse();
    check(oldGap, 30, "old ratio finished");
    check(gap, 18, "divide by three");
    refOutPeriod(p);
    check(p, 12, "ref output divided by two");
    u_rdr_host_model.sendBits(24'h00_0080, 8);
    check({cfgBits, aBits, refOscCtrlBits}, 35'h4_0091_A2B2, "config byte only");
  endtask
  initial
  begin
    repeat (16) @(posedge sysClk);
    #1;
    reset = 1'b0;
    testReset();
    testRegLoad();
    testDetector();
    testALoad();
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge sysClk);
    failures++;
    print_verdict();
  end
endmodule // rdr_ref_divider_test
`default_nettype wire
